// ### shared/link_train_regs.svh
// What this block does
// - Lane 3 local trigger applies its coefficient field
// - Triggers self-clear; writing zero changes nothing
// - Local trigger ignored unless local override set
// - Read-only lane status fields at 8-bit stride
// - Lock error with initial taps means unrecoverable
// - Local request word mirrors transmitted word low bits while partner override clear
// - Local request word writable only under partner override
// - Word holds post, main, pre requests high to low
// - Partner field holds last received frame word
// - Local override swaps protocol for software changes
// - Partner trigger starts sending word, then self-clears
`ifndef LINK_TRAIN_REGS_SVH
`define LINK_TRAIN_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LT_ADDR_CTRL 12'h0d0
`define LT_ADDR_TRIG 12'h0d1
`define LT_ADDR_STATUS 12'h0d2
`define LT_ADDR_UNRECOV 12'h0d3
`define LT_ADDR_COEF_WORDS 12'h0d4
`define LT_ADDR_LCOEF_L0 12'h0dd
`define LT_ADDR_LCOEF_L1 12'h0e1
`define LT_ADDR_LCOEF_L2 12'h0e5
`define LT_ADDR_LCOEF_L3 12'h0e9

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define LT_CTRL_PARTNER_OVR_BIT 16
`define LT_CTRL_LOCAL_OVR_BIT 17
`define LT_TRIG_PARTNER_LSB 4
`define LT_TRIG_LOCAL_LSB 8
`define LT_STATUS_STRIDE 8
`define LT_STATUS_W 6
`define LT_LOCK_ERR_BIT 3
`define LT_LOCAL_WORD_LSB 0
`define LT_PARTNER_WORD_LSB 16
`define LT_LCOEF_LSB 16
`define LT_LCOEF_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LT_CTRL_RST 2'h0
`define LT_LCOEF_RST 8'h00
`define LT_WORD_RST 6'h00
`define LT_RDATA_RST 32'h0000_0000

`endif

// ### shared/link_train_pkg.sv
package link_train_pkg;

	// Two-bit coefficient request code
	typedef enum logic [1:0] {
		COEF_HOLD = 2'h0,
		COEF_INC = 2'h1,
		COEF_DEC = 2'h2,
		COEF_RSVD = 2'h3
	} coef_code_t;

	// Six-bit request word: post [5:4], main [3:2], pre [1:0]
	typedef logic [5:0] coef_word_t;

endpackage : link_train_pkg

// ### rtl/coef_req_filter.sv
`timescale 1ns/1ps
// Replaces the reserved code in each request field by hold
module coef_req_filter
	import link_train_pkg::*;
(
	input wire coef_word_t word_in,
	output coef_word_t word_out
);

	// Field by field, reserved code never leaves this block
	always_comb
	begin
		word_out = word_in;
		for (int f = 0; f < 3; f++)
		begin
			if (coef_code_t'(word_in[2*f +: 2]) == COEF_RSVD)
			begin
				word_out[2*f +: 2] = COEF_HOLD;
			end
		end
	end

endmodule : coef_req_filter

// ### rtl/sc_trigger.sv
`timescale 1ns/1ps
// Self-clearing trigger bit, gated by an enable
module sc_trigger
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic set_req,
	input wire logic allow,
	output logic fire
);

	logic pend_q;

	// Set wins over the self-clear so back-to-back writes are not lost
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pend_q <= 1'b0;
		end
		else if (set_req && allow)
		begin
			pend_q <= 1'b1;
		end
		else
		begin
			pend_q <= 1'b0;
		end
	end

	assign fire = pend_q;

endmodule : sc_trigger

// ### rtl/link_train_coef_override_regs.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "link_train_regs.svh"
// Software register bank for link training coefficient override
module link_train_coef_override_regs
	import link_train_pkg::*;
#(
	parameter int NUM_LANES = 4,
	parameter int TAP_W = 8,
	parameter logic [4*TAP_W-1:0] INIT_TAP = '0
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [4*`LT_STATUS_W-1:0] lane_status,
	input wire logic [4*TAP_W-1:0] lane_tap_setting,
	input wire logic [15:0] tx_word0,
	input wire logic [15:0] rx_word0,
	input wire logic rx_word0_valid,
	output logic local_override_mode,
	output logic partner_override_mode,
	output logic [3:0] local_coef_apply,
	output logic [4*`LT_LCOEF_W-1:0] local_coef_value,
	output logic [3:0] partner_send,
	output coef_word_t partner_word0,
	output logic [3:0] unrecoverable
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic partner_ovr_q;
	logic local_ovr_q;
	logic [`LT_LCOEF_W-1:0] lcoef_q [4];
	logic [`LT_LCOEF_W-1:0] lcoef_val_q [4];
	logic [3:0] apply_q;
	coef_word_t local_coef_request_word_q;
	coef_word_t local_coef_request_word_d;
	coef_word_t partner_coef_request_word_q;
	coef_word_t sw_word_clean;
	logic [3:0] unrecov_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Decoded write strobes
	logic wr_ctrl;
	logic wr_trig;
	logic wr_words;
	logic [3:0] wr_lcoef;

	// Trigger outputs
	logic [3:0] partner_fire;
	logic [3:0] local_fire;

	// Assembled read views
	logic [31:0] status_view;
	logic [31:0] trig_view;
	logic [31:0] words_view;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// Writes are single cycle, no wait states
	assign wr_ctrl = reg_wr && (reg_addr == `LT_ADDR_CTRL);
	assign wr_trig = reg_wr && (reg_addr == `LT_ADDR_TRIG);
	assign wr_words = reg_wr && (reg_addr == `LT_ADDR_COEF_WORDS);
	assign wr_lcoef[0] = reg_wr && (reg_addr == `LT_ADDR_LCOEF_L0);
	assign wr_lcoef[1] = reg_wr && (reg_addr == `LT_ADDR_LCOEF_L1);
	assign wr_lcoef[2] = reg_wr && (reg_addr == `LT_ADDR_LCOEF_L2);
	assign wr_lcoef[3] = reg_wr && (reg_addr == `LT_ADDR_LCOEF_L3);

	// ----------------------------------------------------------------
	// Control register: override enables
	// ----------------------------------------------------------------

	// Both enables are plain read/write level bits
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			partner_ovr_q <= 1'b0;
			local_ovr_q <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			partner_ovr_q <= reg_wdata[`LT_CTRL_PARTNER_OVR_BIT];
			local_ovr_q <= reg_wdata[`LT_CTRL_LOCAL_OVR_BIT];
		end
	end

	// Local override hands coefficient control to software
	assign local_override_mode = local_ovr_q;
	assign partner_override_mode = partner_ovr_q;

	// ----------------------------------------------------------------
	// Self-clearing triggers
	// ----------------------------------------------------------------

	// One trigger per lane and per direction; a zero write sets nothing
	generate
		for (genvar l = 0; l < 4; l++)
		begin : g_trig
			// Partner word send, honoured only under partner override
			sc_trigger u_partner_trig (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.set_req(wr_trig && reg_wdata[`LT_TRIG_PARTNER_LSB + l]),
				.allow(partner_ovr_q),
				.fire(partner_fire[l])
			);
			// Local coefficient apply, honoured only under local override
			sc_trigger u_local_trig (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.set_req(wr_trig && reg_wdata[`LT_TRIG_LOCAL_LSB + l]),
				.allow(local_ovr_q),
				.fire(local_fire[l])
			);
		end
	endgenerate

	// The pending bit itself is the one-cycle send request
	assign partner_send = partner_fire;

	// ----------------------------------------------------------------
	// Local coefficient fields, one per lane
	// ----------------------------------------------------------------

	// Software stages the coefficients before pulsing the trigger
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int l = 0; l < 4; l++)
			begin
				lcoef_q[l] <= `LT_LCOEF_RST;
			end
		end
		else
		begin
			for (int l = 0; l < 4; l++)
			begin
				if (wr_lcoef[l])
				begin
					lcoef_q[l] <= reg_wdata[`LT_LCOEF_LSB +: `LT_LCOEF_W];
				end
			end
		end
	end

	// Apply pulse and the value it carries, both from flops
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			apply_q <= 4'h0;
			for (int l = 0; l < 4; l++)
			begin
				lcoef_val_q[l] <= `LT_LCOEF_RST;
			end
		end
		else
		begin
			apply_q <= local_fire;
			for (int l = 0; l < 4; l++)
			begin
				if (local_fire[l])
				begin
					lcoef_val_q[l] <= lcoef_q[l];
				end
			end
		end
	end

	// Value is held between pulses so the engine may sample late
	assign local_coef_apply = apply_q;
	generate
		for (genvar l = 0; l < 4; l++)
		begin : g_lval
			assign local_coef_value[l*`LT_LCOEF_W +: `LT_LCOEF_W] = lcoef_val_q[l];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Lane 0 coefficient request words
	// ----------------------------------------------------------------

	// Scrub reserved codes from software before they can be sent
	coef_req_filter u_sw_filter (
		.word_in(coef_word_t'(reg_wdata[`LT_LOCAL_WORD_LSB +: 6])),
		.word_out(sw_word_clean)
	);

	// Mirror the sent word unless software owns it
	always_comb
	begin
		local_coef_request_word_d = local_coef_request_word_q;
		if (!partner_ovr_q)
		begin
			local_coef_request_word_d = coef_word_t'(tx_word0[5:0]);
		end
		else if (wr_words)
		begin
			local_coef_request_word_d = sw_word_clean;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			local_coef_request_word_q <= `LT_WORD_RST;
		end
		else
		begin
			local_coef_request_word_q <= local_coef_request_word_d;
		end
	end

	// Post, main, pre fields travel in place; engine sends as stored
	assign partner_word0 = local_coef_request_word_q;

	// Latest received frame word; software cannot write it
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			partner_coef_request_word_q <= `LT_WORD_RST;
		end
		else if (rx_word0_valid)
		begin
			partner_coef_request_word_q <= coef_word_t'(rx_word0[5:0]);
		end
	end

	// ----------------------------------------------------------------
	// Unrecoverable frame-lock error detection
	// ----------------------------------------------------------------

	// Lock error with taps at their initial setting means retry is futile
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			unrecov_q <= 4'h0;
		end
		else
		begin
			for (int l = 0; l < 4; l++)
			begin
				unrecov_q[l] <= lane_status[l*`LT_STATUS_W + `LT_LOCK_ERR_BIT]
					&& (lane_tap_setting[l*TAP_W +: TAP_W] == INIT_TAP[l*TAP_W +: TAP_W]);
			end
		end
	end

	assign unrecoverable = unrecov_q;

	// ----------------------------------------------------------------
	// Read views
	// ----------------------------------------------------------------

	// Six status bits per lane at byte stride, gaps read zero
	always_comb
	begin
		status_view = 32'h0000_0000;
		for (int l = 0; l < 4; l++)
		begin
			status_view[l*`LT_STATUS_STRIDE +: `LT_STATUS_W] =
				lane_status[l*`LT_STATUS_W +: `LT_STATUS_W];
		end
	end

	// Triggers read as their pending state, normally zero
	always_comb
	begin
		trig_view = 32'h0000_0000;
		trig_view[`LT_TRIG_PARTNER_LSB +: 4] = partner_fire;
		trig_view[`LT_TRIG_LOCAL_LSB +: 4] = local_fire;
	end

	// Both request words in one register
	always_comb
	begin
		words_view = 32'h0000_0000;
		words_view[`LT_LOCAL_WORD_LSB +: 6] = local_coef_request_word_q;
		words_view[`LT_PARTNER_WORD_LSB +: 6] = partner_coef_request_word_q;
	end

	// ----------------------------------------------------------------
	// Read data path
	// ----------------------------------------------------------------

	// Unmapped addresses read as zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (reg_addr)
			`LT_ADDR_CTRL:
			begin
				rdata_d[`LT_CTRL_PARTNER_OVR_BIT] = partner_ovr_q;
				rdata_d[`LT_CTRL_LOCAL_OVR_BIT] = local_ovr_q;
			end
			`LT_ADDR_TRIG:
			begin
				rdata_d = trig_view;
			end
			`LT_ADDR_STATUS:
			begin
				rdata_d = status_view;
			end
			`LT_ADDR_UNRECOV:
			begin
				rdata_d[3:0] = unrecov_q;
			end
			`LT_ADDR_COEF_WORDS:
			begin
				rdata_d = words_view;
			end
			`LT_ADDR_LCOEF_L0:
			begin
				rdata_d[`LT_LCOEF_LSB +: `LT_LCOEF_W] = lcoef_q[0];
			end
			`LT_ADDR_LCOEF_L1:
			begin
				rdata_d[`LT_LCOEF_LSB +: `LT_LCOEF_W] = lcoef_q[1];
			end
			`LT_ADDR_LCOEF_L2:
			begin
				rdata_d[`LT_LCOEF_LSB +: `LT_LCOEF_W] = lcoef_q[2];
			end
			`LT_ADDR_LCOEF_L3:
			begin
				rdata_d[`LT_LCOEF_LSB +: `LT_LCOEF_W] = lcoef_q[3];
			end
			default:
			begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// Data appears in the cycle after the read strobe and holds until the next read
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q <= `LT_RDATA_RST;
		end
		else if (reg_rd)
		begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : link_train_coef_override_regs

// ### testbench/link_train_checker_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module link_train_checker
	import link_train_pkg::*;
#(
	parameter int TAP_W = 8,
	parameter logic [4*TAP_W-1:0] INIT_TAP = '0
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [23:0] lane_status,
	input wire logic [4*TAP_W-1:0] lane_tap_setting,
	input wire logic [15:0] tx_word0,
	input wire logic [15:0] rx_word0,
	input wire logic rx_word0_valid,
	input wire logic local_override_mode,
	input wire logic partner_override_mode,
	input wire logic [3:0] local_coef_apply,
	input wire logic [31:0] local_coef_value,
	input wire logic [3:0] partner_send,
	input wire coef_word_t partner_word0,
	input wire logic [3:0] unrecoverable
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// Decoded requests and expected views
	wire logic [1:0] ctl = reg_wdata[17:16];
	wire logic trig_wr = reg_wr && reg_addr == 12'h0d1;
	wire logic ps0_req = trig_wr && reg_wdata[4] && partner_override_mode;
	wire logic lt3_req = trig_wr && reg_wdata[11] && local_override_mode;
	wire logic [7:0] lc3 = local_coef_value[31:24];
	wire logic [5:0] txl = tx_word0[5:0];
	wire logic ur1 = lane_status[9] && lane_tap_setting[2*TAP_W-1:TAP_W] ==
		INIT_TAP[2*TAP_W-1:TAP_W];
	wire logic [31:0] sview = {2'b00, lane_status[23:18], 2'b00, lane_status[17:12],
		2'b00, lane_status[11:6], 2'b00, lane_status[5:0]};
	logic [5:0] rx_hold_q;

	// Own copy of the last received word; read data lags it by one edge
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
			rx_hold_q <= 6'h00;
		else if (rx_word0_valid)
			rx_hold_q <= rx_word0[5:0];

	sequence local_trig_s;
		lt3_req;
	endsequence

	mode_follow_a: assert property (
		reg_wr && reg_addr == 12'h0d0 |=>
		{local_override_mode, partner_override_mode} == $past(ctl))
		else $error("override modes do not follow control write");
	status_view_a: assert property (
		reg_rd && reg_addr == 12'h0d2 |=> reg_rdata == $past(sview))
		else $error("status read does not show lane fields");
	partner_send_a: assert property (ps0_req |=> partner_send[0])
		else $error("partner trigger gave no send pulse");
	send_selfclr_a: assert property (
		partner_send[0] && !ps0_req |=> !partner_send[0])
		else $error("send pulse did not clear");
	local_apply_a: assert property (local_trig_s |-> ##2 local_coef_apply[3])
		else $error("local trigger gave no apply pulse");
	local_gate_a: assert property (local_coef_apply[3] |-> $past(lt3_req, 2))
		else $error("apply pulse without enabled trigger");
	coef_value_a: assert property ($changed(lc3) |-> local_coef_apply[3])
		else $error("lane three value moved without apply");
	word_mirror_a: assert property (
		!partner_override_mode |=> partner_word0 == $past(txl))
		else $error("local word does not mirror sent word");
	no_reserved_a: assert property (
		partner_send[0] |-> partner_word0[5:4] != 2'h3 &&
		partner_word0[3:2] != 2'h3 && partner_word0[1:0] != 2'h3)
		else $error("reserved code offered for sending");
	rx_capture_a: assert property (
		reg_rd && reg_addr == 12'h0d4 |=> reg_rdata[21:16] == $past(rx_hold_q))
		else $error("partner field is not last received word");
	unrec_flag_a: assert property (1'b1 |=> unrecoverable[1] == $past(ur1))
		else $error("lane one unrecoverable flag wrong");
endmodule : link_train_checker

bind link_train_coef_override_regs link_train_checker #(.TAP_W(TAP_W),
	.INIT_TAP(INIT_TAP)) link_train_checker_i (.ref_clk, .resetn, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lane_status, .lane_tap_setting,
	.tx_word0, .rx_word0, .rx_word0_valid, .local_override_mode,
	.partner_override_mode, .local_coef_apply, .local_coef_value, .partner_send,
	.partner_word0, .unrecoverable);

// ### testbench/link_partner_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Remote link partner
// ----------------------------------------------------------------
module link_partner_model
	import link_train_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic frame_go,
	input wire logic [15:0] frame_word,
	input wire logic slow,
	input wire logic [3:0] partner_send,
	input wire coef_word_t partner_word0,
	output logic [15:0] rx_word0,
	output logic rx_word0_valid,
	output coef_word_t heard_word,
	output logic [7:0] heard_cnt
);
	logic go_q;
	logic [15:0] word_q;
	wire logic now = (frame_go && !slow) || go_q;

	// Frame delivery, prompt or a cycle late; between frames the word
	// toggles so a stale capture cannot pass for a fresh one
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
		begin
			go_q <= 1'b0;
			word_q <= 16'h0000;
			rx_word0 <= 16'h0000;
			rx_word0_valid <= 1'b0;
		end
		else
		begin
			go_q <= frame_go && slow;
			word_q <= frame_word;
			rx_word0_valid <= now;
			rx_word0 <= now ? (go_q ? word_q : frame_word) : ~rx_word0;
		end

	// Word taken off the wire for every lane 0 send cycle
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
		begin
			heard_word <= 6'h00;
			heard_cnt <= 8'h00;
		end
		else if (partner_send[0])
		begin
			heard_word <= partner_word0;
			heard_cnt <= heard_cnt + 8'h01;
		end
endmodule : link_partner_model

// ### testbench/tb_link_train_coef_override_regs.sv
`timescale 1ns/1ps
module tb_link_train_coef_override_regs;
	import link_train_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [23:0] lane_status = 24'h00_0000;
	logic [31:0] lane_tap_setting = 32'h0000_0000;
	logic [15:0] tx_word0 = 16'h0000;
	logic [15:0] rx_word0;
	logic [15:0] frame_word = 16'h0000;
	logic rx_word0_valid;
	logic frame_go = 1'b0;
	logic slow = 1'b0;
	logic local_override_mode;
	logic partner_override_mode;
	logic [3:0] local_coef_apply;
	logic [3:0] partner_send;
	logic [3:0] unrecoverable;
	logic [31:0] local_coef_value;
	coef_word_t partner_word0;
	coef_word_t heard_word;
	logic [7:0] heard_cnt;
	logic [7:0] apply_cnt = 8'h00;
	int errors = 0;
	int comparisons = 0;

	// ----------------------------------------------------------------
	// Clock, design and partner
	// ----------------------------------------------------------------
	initial
		forever #5 ref_clk = ~ref_clk;

	link_train_coef_override_regs link_train_coef_override_regs_i (.ref_clk(ref_clk),
		.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_status(lane_status),
		.lane_tap_setting(lane_tap_setting), .tx_word0(tx_word0), .rx_word0(rx_word0),
		.rx_word0_valid(rx_word0_valid), .local_override_mode(local_override_mode),
		.partner_override_mode(partner_override_mode),
		.local_coef_apply(local_coef_apply), .local_coef_value(local_coef_value),
		.partner_send(partner_send), .partner_word0(partner_word0),
		.unrecoverable(unrecoverable));

	link_partner_model link_partner_model_i (.ref_clk(ref_clk), .resetn(resetn),
		.frame_go(frame_go), .frame_word(frame_word), .slow(slow),
		.partner_send(partner_send), .partner_word0(partner_word0),
		.rx_word0(rx_word0), .rx_word0_valid(rx_word0_valid),
		.heard_word(heard_word), .heard_cnt(heard_cnt));

	// Apply pulses on lane three, counted per cycle
	always @(posedge ref_clk)
		if (local_coef_apply[3])
			apply_cnt <= apply_cnt + 8'h01;

	// ----------------------------------------------------------------
	// Bus tasks and verdict
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Each access opens on a clock edge; the strobe drops at the next edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Data taken one edge after it appears; it holds until the next read
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask : rd

	task automatic finish_test;
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// Bound well above the fewer than one hundred cycles the tests need
	initial
	begin
		#20us;
		errors++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] d;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		check("override modes", 32'h0000_0000, {local_override_mode, partner_override_mode});
		lane_status <= {6'h2a, 6'h08, 6'h0b, 6'h15};
		lane_tap_setting <= 32'h0005_0000;
		rd(12'h0d2, d);
		check("status", 32'h2a08_0b15, d);
		rd(12'h0d3, d);
		check("unrecoverable", 32'h0000_000a, d[3:0]);
		check("unrecoverable port", 32'h0000_000a, unrecoverable);
		rd(12'h0d5, d);
		check("unmapped", 32'h0000_0000, d);
		tx_word0 <= 16'hff26;
		wr(12'h0d4, 32'h0000_0011);
		rd(12'h0d4, d);
		check("local word", 32'h0000_0026, d[5:0]);
		for (int s = 0; s < 2; s++)
		begin
			slow <= s[0];
			frame_word <= s[0] ? 16'h0007 : 16'hc015;
			frame_go <= 1'b1;
			@(posedge ref_clk);
			frame_go <= 1'b0;
			repeat (3) @(posedge ref_clk);
			rd(12'h0d4, d);
			check("partner field", s[0] ? 32'h7 : 32'h15, d[21:16]);
		end
		// Override first, then program the word, then trigger twice
		wr(12'h0d0, 32'h0001_0000);
		tx_word0 <= 16'h0009;
		wr(12'h0d4, 32'h0000_0037);
		repeat (2) wr(12'h0d1, 32'h0000_0010);
		repeat (2) @(posedge ref_clk);
		check("heard count", 32'h0000_0002, heard_cnt);
		check("heard word", 32'h0000_0004, heard_word);
		rd(12'h0d4, d);
		check("written word", 32'h0000_0004, d[5:0]);
		wr(12'h0e9, 32'h005a_0000);
		rd(12'h0e9, d);
		check("lane three coef", 32'h005a_0000, d);
		wr(12'h0d1, 32'h0000_0800);
		repeat (3) @(posedge ref_clk);
		check("refused apply", 32'h0000_0000, apply_cnt);
		wr(12'h0d0, 32'h0002_0000);
		wr(12'h0d1, 32'h0000_0800);
		wr(12'h0d1, 32'h0000_0000);
		repeat (3) @(posedge ref_clk);
		check("apply count", 32'h0000_0001, apply_cnt);
		check("lane three value", 32'h0000_005a, local_coef_value[31:24]);
		check("modes", 32'h0000_0002, {local_override_mode, partner_override_mode});
		rd(12'h0d4, d);
		check("mirror again", 32'h0000_0009, d[5:0]);
		finish_test();
	end
endmodule : tb_link_train_coef_override_regs
